// >>> pfc_consts.svh
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

//----------------------------------------
// Geometry
//----------------------------------------
`define PFC_PIX_W 10
`define PFC_CRD_W 5
`define PFC_IMG_LAST 5'h1F
`define PFC_BLK_SH 3
`define PFC_GRID 5
`define PFC_NODES 25
`define PFC_SLOTS 4
`define PFC_USR_N 4
`define PFC_TAP_MAX 10
`define PFC_PIX_MAX 10'h3FF

//----------------------------------------
// Register byte addresses
//----------------------------------------
`define PFC_A_CTRL 8'h00
`define PFC_A_CMD 8'h04
`define PFC_A_SLOT 8'h08
`define PFC_A_TGT 8'h0C
`define PFC_A_STAT 8'h10
`define PFC_A_DIDX 8'h14
`define PFC_A_DDAT 8'h18

//----------------------------------------
// Field positions and reset values
//----------------------------------------
`define PFC_B_DEF_EN 0
`define PFC_B_FF_EN 1
`define PFC_B_FMT8 2
`define PFC_B_TAP_LO 4
`define PFC_B_GEN 0
`define PFC_B_SAVE 1
`define PFC_B_LOAD 2
`define PFC_B_DVLD 16
`define PFC_TGT_RST 10'h200

//----------------------------------------
// Factory defect list {y, x}
//----------------------------------------
`define PFC_FDEF0 10'h0A5
`define PFC_FDEF1 10'h0A6
`define PFC_FDEF2 10'h14C
`define PFC_FDEF3 10'h3E1

`endif

// >>> pfc_pkg.sv
`include "pfc_consts.svh"

package pfc_pkg;

    //----------------------------------------
    // Reference generation states, Gray coded
    //----------------------------------------
    typedef enum logic [1:0]
    {
        PFC_GEN_IDLE = 2'b00,
        PFC_GEN_ARM = 2'b01,
        PFC_GEN_GRAB = 2'b11
    } pfc_gen_t;

    typedef logic [`PFC_PIX_W-1:0] pfc_pix_t;
    typedef logic [`PFC_CRD_W-1:0] pfc_crd_t;

    //----------------------------------------
    // Whole state of the correction block
    //----------------------------------------
    typedef struct packed
    {
        logic [2:0] pc_s;
        logic pc_lvl;
        logic [2:0] lv_s;
        logic [2:0] fv_s;
        logic [2:0][`PFC_PIX_W-1:0] dat_s;
        logic lv_prev;
        logic fv_prev;
        pfc_crd_t xc;
        pfc_crd_t yc;
        logic first_line;
        logic [6:0][`PFC_PIX_W-1:0] wp;
        logic [6:0] wbad;
        logic [6:0] wvld;
        logic [6:0][`PFC_CRD_W-1:0] wx;
        logic def_en;
        logic ff_en;
        logic fmt8;
        logic [1:0] tap_sel;
        logic [1:0] slot;
        pfc_pix_t tgt;
        logic [1:0] udef_idx;
        logic [`PFC_USR_N-1:0][2*`PFC_CRD_W:0] udef;
        pfc_gen_t gen;
        logic ref_ok;
        logic [`PFC_NODES-1:0][`PFC_PIX_W-1:0] act;
        logic [`PFC_SLOTS-1:0][`PFC_NODES-1:0][`PFC_PIX_W-1:0] slots;
        logic [3:0] cnt;
        logic [`PFC_TAP_MAX-1:0][`PFC_PIX_W-1:0] tbuf;
        logic [`PFC_TAP_MAX-1:0][`PFC_PIX_W-1:0] tout;
        logic tvld;
        logic fact;
        logic [31:0] rdata;
    } pfc_state_t;

endpackage : pfc_pkg

// >>> pfc_core.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "pfc_consts.svh"

module pfc_core
    import pfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic pix_clk,
    input wire logic pix_fval,
    input wire logic pix_lval,
    input wire logic [9:0] pix_data,
    output logic [`PFC_TAP_MAX*`PFC_PIX_W-1:0] tap_data,
    output logic tap_valid,
    output logic frame_active
);

    //----------------------------------------
    // Helper functions
    //----------------------------------------

    // Grid node that a coordinate lands on, {hit, index}
    function automatic logic [3:0] node_hit(input pfc_crd_t c);
        logic [3:0] r;
        r = 4'h0;
        if (c[`PFC_BLK_SH-1:0] == 3'h0)
        begin
            r = {1'b1, 1'b0, c[4:3]};
        end
        else if (c == `PFC_IMG_LAST)
        begin
            r = 4'hC;
        end
        return r;
    endfunction : node_hit

    // Listed defect check against factory and user entries
    function automatic logic is_defect(input pfc_crd_t x, input pfc_crd_t y,
        input logic [`PFC_USR_N-1:0][2*`PFC_CRD_W:0] ud);
        logic [2*`PFC_CRD_W-1:0] k;
        logic r;
        k = {y, x};
        r = (k == `PFC_FDEF0) || (k == `PFC_FDEF1) || (k == `PFC_FDEF2) ||
            (k == `PFC_FDEF3);
        for (int i = 0; i < `PFC_USR_N; i++)
        begin
            r = r | (ud[i][`PFC_B_DVLD-6] && ud[i][2*`PFC_CRD_W-1:0] == k);
        end
        return r;
    endfunction : is_defect

    // Rounded-down mean of two levels
    function automatic pfc_pix_t avg2(input pfc_pix_t a, input pfc_pix_t b);
        logic [`PFC_PIX_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[`PFC_PIX_W:1];
    endfunction : avg2

    // Defect replacement on a seven-pixel window, centre at 3
    function automatic pfc_pix_t fix_px(input logic [6:0][`PFC_PIX_W-1:0] p,
        input logic [6:0] bad);
        pfc_pix_t r;
        logic done;
        r = p[3];
        done = !bad[3];
        for (int k = 1; k <= 3; k++)
        begin
            if (!done && !bad[3-k] && !bad[3+k])
            begin
                r = avg2(p[3-k], p[3+k]);
                done = 1'b1;
            end
            else if (!done && !bad[3-k])
            begin
                r = p[3-k];
                done = 1'b1;
            end
            else if (!done && !bad[3+k])
            begin
                r = p[3+k];
                done = 1'b1;
            end
        end
        return r;
    endfunction : fix_px

    // Bilinear blend of four grid nodes
    function automatic pfc_pix_t blend(input pfc_pix_t a, input pfc_pix_t b,
        input pfc_pix_t c, input pfc_pix_t d, input logic [2:0] fx, input logic [2:0] fy);
        logic [13:0] top;
        logic [13:0] bot;
        logic [17:0] s;
        top = 14'(a * (4'h8 - {1'b0, fx})) + 14'(b * fx);
        bot = 14'(c * (4'h8 - {1'b0, fx})) + 14'(d * fx);
        s = 18'(top * (4'h8 - {1'b0, fy})) + 18'(bot * fy);
        return s[15:6];
    endfunction : blend

    //----------------------------------------
    // State and next state
    //----------------------------------------
    pfc_state_t q;
    pfc_state_t d;

    logic ev;
    logic [3:0] hx;
    logic [3:0] hy;
    logic [4:0] ni;
    logic [4:0] by5;
    pfc_pix_t fixed;
    pfc_pix_t fref;
    pfc_pix_t outp;
    logic [19:0] prod;
    logic [19:0] quo;
    logic [3:0] ntap;
    logic inbad;

    //----------------------------------------
    // Next-state logic
    //----------------------------------------
    always_comb
    begin
        d = q;
        d.tvld = 1'b0;
        d.rdata = 32'h0000_0000;
        // Three-stage capture of link pins
        d.pc_s = {q.pc_s[1:0], pix_clk};
        d.lv_s = {q.lv_s[1:0], pix_lval};
        d.fv_s = {q.fv_s[1:0], pix_fval};
        d.dat_s = {q.dat_s[1:0], pix_data};
        ev = 1'b0;
        if (q.pc_s[1] == q.pc_s[2])
        begin
            d.pc_lvl = q.pc_s[2];
            ev = q.pc_s[2] && !q.pc_lvl;
        end

        // Defect replacement, then interpolated reference and division
        fixed = q.def_en ? fix_px(q.wp, q.wbad) : q.wp[3];
        hy = node_hit(q.yc);
        by5 = 5'({q.yc[4:3], 2'b00} + {3'b000, q.yc[4:3]});
        ni = 5'(by5 + {3'b000, q.wx[3][4:3]});
        fref = blend(q.act[ni], q.act[5'(ni + 5'h01)], q.act[5'(ni + 5'h05)],
            q.act[5'(ni + 5'h06)], q.wx[3][2:0], q.yc[2:0]);
        prod = fixed * q.tgt;
        quo = (fref == 10'h000) ? {10'h000, fixed} : prod / {10'h000, fref};
        outp = fixed;
        if (q.ff_en && q.gen != PFC_GEN_GRAB)
        begin
            outp = (quo > {10'h000, `PFC_PIX_MAX}) ? `PFC_PIX_MAX : quo[9:0];
        end
        if (q.fmt8)
        begin
            outp = {2'b00, outp[9:2]};
        end

        // Tap count from the mode field
        case (q.tap_sel)
            2'h0: ntap = 4'h2;
            2'h1: ntap = 4'h4;
            2'h2: ntap = 4'h8;
            default: ntap = 4'hA;
        endcase

        hx = node_hit(q.wx[3]);
        inbad = is_defect(q.xc, q.yc, q.udef);
        if (ev)
        begin
            // Line and frame position tracking
            d.fv_prev = q.fv_s[2];
            d.lv_prev = q.lv_s[2];
            d.fact = q.fv_s[2];
            if (!q.fv_s[2])
            begin
                d.first_line = 1'b1;
                d.yc = '0;
            end
            if (q.lv_s[2] && !q.lv_prev)
            begin
                d.first_line = 1'b0;
                d.yc = q.first_line ? '0 : pfc_crd_t'(q.yc + 5'h01);
            end
            d.xc = (q.lv_s[2] && q.lv_prev) ? pfc_crd_t'(q.xc + 5'h01) : '0;
            // Look up the pixel that enters now, not the one before it
            inbad = is_defect(d.xc, d.yc, q.udef);

            // Pack the centre pixel into interleaved taps
            if (q.wvld[3])
            begin
                d.tbuf[q.cnt] = outp;
                d.cnt = 4'(q.cnt + 4'h1);
                if (4'(q.cnt + 4'h1) == ntap)
                begin
                    d.tout = d.tbuf;
                    d.tvld = 1'b1;
                    d.cnt = 4'h0;
                    d.tbuf = '0;
                end
            end
            else if (q.cnt != 4'h0)
            begin
                d.tout = q.tbuf;
                d.tvld = 1'b1;
                d.cnt = 4'h0;
                d.tbuf = '0;
            end

            // Reference capture at grid nodes during the grabbed frame
            if (q.gen == PFC_GEN_GRAB && q.wvld[3] && hx[3] && hy[3])
            begin
                d.act[5'({hy[2:0], 2'b00} + {2'b00, hy[2:0]}
                    + {2'b00, hx[2:0]})] = fixed;
            end

            // Shift the window; out-of-line slots count as defective
            d.wp = {q.wp[5:0], q.dat_s[2]};
            d.wvld = {q.wvld[5:0], q.lv_s[2]};
            d.wbad = {q.wbad[5:0], !q.lv_s[2] || inbad};
            d.wx = {q.wx[5:0], d.xc};

            // Generation sequencing on frame edges
            case (q.gen)
                PFC_GEN_ARM:
                begin
                    if (q.fv_s[2] && !q.fv_prev)
                    begin
                        d.gen = PFC_GEN_GRAB;
                    end
                end
                PFC_GEN_GRAB:
                begin
                    if (!q.fv_s[2] && !q.wvld[3])
                    begin
                        d.gen = PFC_GEN_IDLE;
                        d.ref_ok = 1'b1;
                    end
                end
                default:
                begin
                    d.gen = q.gen;
                end
            endcase
        end

        // Register writes
        if (reg_wr)
        begin
            case (reg_addr)
                `PFC_A_CTRL:
                begin
                    d.def_en = reg_wdata[`PFC_B_DEF_EN];
                    d.ff_en = reg_wdata[`PFC_B_FF_EN];
                    d.fmt8 = reg_wdata[`PFC_B_FMT8];
                    d.tap_sel = reg_wdata[`PFC_B_TAP_LO+1:`PFC_B_TAP_LO];
                end
                `PFC_A_CMD:
                begin
                    if (reg_wdata[`PFC_B_GEN])
                    begin
                        d.gen = PFC_GEN_ARM;
                        d.ref_ok = d.ref_ok && !q.ref_ok; // Completion this cycle wins only if ref_ok was clear before
                    end
                    else if (reg_wdata[`PFC_B_SAVE])
                    begin
                        d.slots[q.slot] = q.act;
                    end
                    else if (reg_wdata[`PFC_B_LOAD])
                    begin
                        d.act = q.slots[q.slot];
                        d.ref_ok = 1'b1;
                    end
                end
                `PFC_A_SLOT: d.slot = reg_wdata[1:0];
                `PFC_A_TGT: d.tgt = reg_wdata[9:0];
                `PFC_A_DIDX: d.udef_idx = reg_wdata[1:0];
                `PFC_A_DDAT: d.udef[q.udef_idx] = {reg_wdata[`PFC_B_DVLD], reg_wdata[12:8],
                    reg_wdata[4:0]};
                default: d.udef_idx = q.udef_idx;
            endcase
        end

        // Register reads, data one cycle later
        if (reg_rd)
        begin
            case (reg_addr)
                `PFC_A_CTRL: d.rdata = {26'h0, q.tap_sel, 1'b0, q.fmt8, q.ff_en, q.def_en};
                `PFC_A_SLOT: d.rdata = {30'h0, q.slot};
                `PFC_A_TGT: d.rdata = {22'h0, q.tgt};
                `PFC_A_STAT: d.rdata = {28'h0, q.fact, q.ref_ok, q.gen};
                `PFC_A_DIDX: d.rdata = {30'h0, q.udef_idx};
                `PFC_A_DDAT: d.rdata = {15'h0, q.udef[q.udef_idx][10], 3'h0,
                    q.udef[q.udef_idx][9:5], 3'h0, q.udef[q.udef_idx][4:0]};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
    end

    //----------------------------------------
    // State register; slots survive reset
    //----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        q <= d;
        if (!rst_b)
        begin
            q <= '0;
            q.tgt <= `PFC_TGT_RST;
            q.wbad <= 7'h7F;
            q.first_line <= 1'b1;
            q.slots <= q.slots;
        end
    end

    //----------------------------------------
    // Outputs
    //----------------------------------------
    assign reg_rdata = q.rdata;
    assign tap_data = q.tout;
    assign tap_valid = q.tvld;
    assign frame_active = q.fact;

endmodule : pfc_core

// >>> pfc_grabber.sv
`timescale 1ns/100ps

//--------------------
// Frame grabber end of the tap link
//--------------------
module pfc_grabber
(
    input wire logic sys_clk,
    input wire logic tap_valid,
    input wire logic [99:0] tap_data,
    input wire logic [3:0] ntap
);
    logic [9:0] got[$];

    // Unpack each group lane by lane, lowest tap first
    always @(posedge sys_clk)
    begin
        if (tap_valid)
            for (int i = 0; i < ntap; i++)
                got.push_back(tap_data[10*i +: 10]);
    end
endmodule : pfc_grabber

// >>> pfc_properties.sv
`timescale 1ns/100ps
`include "pfc_consts.svh"

//--------------------
// Port checker
//--------------------
module pfc_properties
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic pix_clk,
    input wire logic pix_fval,
    input wire logic pix_lval,
    input wire logic [9:0] pix_data,
    input wire logic [`PFC_TAP_MAX*`PFC_PIX_W-1:0] tap_data,
    input wire logic tap_valid,
    input wire logic frame_active
);
    logic [5:0] ctrl_q;
    logic [6:0] ntap;
    logic [99:0] tap_mask;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Shadow of the control word
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            ctrl_q <= 6'h00;
        else if (reg_wr && reg_addr == `PFC_A_CTRL)
            ctrl_q <= reg_wdata[5:0];
    end

    // Lanes in use for the chosen tap mode
    always_comb
    begin
        case (ctrl_q[5:4])
            2'h0: ntap = 7'h02;
            2'h1: ntap = 7'h04;
            2'h2: ntap = 7'h08;
            default: ntap = 7'h0A;
        endcase
        tap_mask = ~(~100'h0 << (10 * ntap));
    end

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not idle");
    slot_readback_a: assert property (reg_wr && reg_addr == `PFC_A_SLOT ##1
        reg_rd && reg_addr == `PFC_A_SLOT |=> reg_rdata == ($past(reg_wdata, 2) & 32'h3))
        else $error("slot readback wrong");
    ctrl_readback_a: assert property (reg_wr && reg_addr == `PFC_A_CTRL ##1
        reg_rd && reg_addr == `PFC_A_CTRL |=> reg_rdata == ($past(reg_wdata, 2) & 32'h37))
        else $error("control readback wrong");
    cmd_reads_zero_a: assert property (reg_rd && reg_addr == `PFC_A_CMD |=> reg_rdata == 0)
        else $error("command reads nonzero");
    tap_pulse_a: assert property (tap_valid |=> !tap_valid)
        else $error("tap valid longer than one cycle");
    tap_hold_a: assert property (!tap_valid |-> $stable(tap_data))
        else $error("tap data moved without valid");
    tap_width_a: assert property (tap_valid |-> (tap_data & ~tap_mask) == 100'h0)
        else $error("unused taps not zero");
    fmt8_msb_a: assert property (tap_valid && ctrl_q[2] |->
        tap_data[9:8] == 2'h0 && tap_data[19:18] == 2'h0)
        else $error("8-bit format upper bits set");
    frame_seen_a: assert property ($rose(pix_fval) |-> ##[1:40] frame_active)
        else $error("frame start not seen");
    frame_end_a: assert property ($fell(pix_fval) |-> ##[1:40] !frame_active)
        else $error("frame end not seen");
endmodule : pfc_properties

bind pfc_core pfc_properties chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pix_clk(pix_clk), .pix_fval(pix_fval), .pix_lval(pix_lval), .pix_data(pix_data),
    .tap_data(tap_data), .tap_valid(tap_valid), .frame_active(frame_active));

// >>> testbench.sv
`timescale 1ns/100ps
`include "pfc_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module testbench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic pix_clk = 1'b0;
    logic pix_fval = 1'b0;
    logic pix_lval = 1'b0;
    logic [9:0] pix_data = 10'h000;
    logic [99:0] tap_data;
    logic tap_valid;
    logic frame_active;
    logic [3:0] ntap = 4'h2;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    bit def_on, ff_on, fmt8_on, flat;
    int ux[4] = '{20, 21, 22, 31};
    int uy[4] = '{2, 2, 2, 5};

    // System clock, and a free pixel clock of unrelated phase
    always #4 sys_clk = ~sys_clk;
    initial
    begin
        #3.3;
        forever #62.5 pix_clk = ~pix_clk;
    end

    pfc_core dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pix_clk(pix_clk), .pix_fval(pix_fval), .pix_lval(pix_lval), .pix_data(pix_data),
        .tap_data(tap_data), .tap_valid(tap_valid), .frame_active(frame_active));
    pfc_grabber grab_u (.sys_clk(sys_clk), .tap_valid(tap_valid), .tap_data(tap_data),
        .ntap(ntap));

    //--------------------
    // Reference model
    //--------------------
    function automatic logic [9:0] src(input int x, input int y);
        return flat ? 10'h100 : 10'((x * 29 + y * 7 + 100) & 1023);
    endfunction : src

    // Listed defects and pixels outside the line count as unusable
    function automatic bit bad(input int x, input int y);
        logic [9:0] f[4] = '{`PFC_FDEF0, `PFC_FDEF1, `PFC_FDEF2, `PFC_FDEF3};
        if (x < 0 || x > 31)
            return 1'b1;
        for (int i = 0; i < 4; i++)
            if (f[i] == {5'(y), 5'(x)} || (ux[i] == x && uy[i] == y))
                return 1'b1;
        return 1'b0;
    endfunction : bad

    // Nearest usable pair, else the usable side, then gain and format
    function automatic logic [9:0] expv(input int x, input int y);
        int v;
        bit done;
        v = src(x, y);
        done = 1'b0;
        if (def_on && bad(x, y))
            for (int d = 1; d <= 3 && !done; d++)
            begin
                done = 1'b1;
                if (!bad(x - d, y) && !bad(x + d, y))
                    v = (src(x - d, y) + src(x + d, y)) / 2;
                else if (!bad(x - d, y))
                    v = src(x - d, y);
                else if (!bad(x + d, y))
                    v = src(x + d, y);
                else
                    done = 1'b0;
            end
        if (ff_on)
            v = (2 * v > 1023) ? 1023 : 2 * v;
        if (fmt8_on)
            v = v >> 2;
        return 10'(v);
    endfunction : expv

    //--------------------
    // Drivers
    //--------------------
    // Write strobe stays up until the next transfer replaces it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
    endtask : wr

    // Read data is judged in the one cycle it stands
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        `CHK(reg_rdata, e)
        @(posedge sys_clk);
    endtask : rd

    task automatic do_reset();
        reg_wr <= 1'b0;
        rst_b <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (5) @(negedge pix_clk);
        @(posedge sys_clk);
    endtask : do_reset

    // Lines of 32 pixels; data toggles while the line is blank
    task automatic send_frame(input int nl);
        reg_wr <= 1'b0;
        grab_u.got.delete();
        @(negedge pix_clk);
        pix_fval <= 1'b1;
        repeat (4) @(negedge pix_clk);
        for (int y = 0; y < nl; y++)
        begin
            for (int x = 0; x < 32; x++)
            begin
                pix_lval <= 1'b1;
                pix_data <= src(x, y);
                @(negedge pix_clk);
            end
            pix_lval <= 1'b0;
            pix_data <= ~pix_data;
            repeat (6) @(negedge pix_clk);
        end
        pix_fval <= 1'b0;
        repeat (10) @(negedge pix_clk);
        @(posedge sys_clk);
    endtask : send_frame

    // Lines padded with zero lanes up to a whole group
    task automatic check_frame(input int nl);
        logic [9:0] e[$];
        for (int y = 0; y < nl; y++)
        begin
            for (int x = 0; x < 32; x++)
                e.push_back(expv(x, y));
            while (e.size() % ntap != 0)
                e.push_back(10'h000);
        end
        `CHK(grab_u.got.size(), e.size())
        foreach (e[i])
            `CHK(grab_u.got[i], e[i])
    endtask : check_frame

    //--------------------
    // Scenarios
    //--------------------
    task automatic test_regs();
        rd(`PFC_A_CTRL, 32'h0);
        rd(`PFC_A_TGT, 32'h200);
        wr(`PFC_A_TGT, 32'hFFFF_F155);
        rd(`PFC_A_TGT, 32'h155);
        wr(`PFC_A_TGT, 32'(`PFC_TGT_RST));
        rd(`PFC_A_STAT, 32'h0);
        wr(`PFC_A_SLOT, 32'hFFFFFFF3);
        rd(`PFC_A_SLOT, 32'h3);
        wr(`PFC_A_CMD, 32'h0);
        rd(`PFC_A_CMD, 32'h0);
        rd(8'h20, 32'h0);
        $display("test_regs done");
    endtask : test_regs

    // Every tap mode; division on with an empty reference
    task automatic test_taps();
        for (int m = 0; m < 4; m++)
        begin
            ntap = (m == 3) ? 4'hA : 4'h2 << m;
            fmt8_on = (m == 1);
            wr(`PFC_A_CTRL, {26'h0, 2'(m), 1'b0, fmt8_on, 2'h2});
            rd(`PFC_A_CTRL, {26'h0, 2'(m), 1'b0, fmt8_on, 2'h2});
            send_frame(2);
            check_frame(2);
        end
        fmt8_on = 1'b0;
        ntap = 4'h2;
        $display("test_taps done");
    endtask : test_taps

    task automatic test_defects();
        for (int i = 0; i < 4; i++)
        begin
            wr(`PFC_A_DIDX, 32'(i));
            wr(`PFC_A_DDAT, {15'h0, 1'b1, 3'h0, 5'(uy[i]), 3'h0, 5'(ux[i])});
        end
        rd(`PFC_A_DIDX, 32'h3);
        rd(`PFC_A_DDAT, {15'h0, 1'b1, 3'h0, 5'(uy[3]), 3'h0, 5'(ux[3])});
        def_on = 1'b1;
        wr(`PFC_A_CTRL, 32'h1);
        send_frame(6);
        check_frame(6);
        $display("test_defects done");
    endtask : test_defects

    // Build a reference, save it, lose it by reset, load it back
    task automatic test_flat();
        wr(`PFC_A_CTRL, 32'h1);
        wr(`PFC_A_CMD, 32'h1);
        rd(`PFC_A_STAT, 32'h1);
        flat = 1'b1;
        send_frame(32);
        rd(`PFC_A_STAT, 32'h4);
        flat = 1'b0;
        def_on = 1'b0;
        ff_on = 1'b1;
        wr(`PFC_A_CTRL, 32'h2);
        send_frame(2);
        check_frame(2);
        wr(`PFC_A_SLOT, 32'h1);
        wr(`PFC_A_CMD, 32'h2);
        do_reset();
        rd(`PFC_A_STAT, 32'h0);
        wr(`PFC_A_CTRL, 32'h2);
        ff_on = 1'b0;
        send_frame(2);
        check_frame(2);
        wr(`PFC_A_SLOT, 32'h1);
        wr(`PFC_A_CMD, 32'h4);
        ff_on = 1'b1;
        send_frame(2);
        check_frame(2);
        $display("test_flat done");
    endtask : test_flat

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // Cut a hang short
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    // Main sequence
    initial
    begin
        do_reset();
        test_regs();
        test_taps();
        test_defects();
        test_flat();
        report_and_stop();
    end
endmodule : testbench
